// File: design/icu_cfg.svh
// Holds the offsets, field positions, reset values and timing counts of the interrupt controller.
// Assumes byte addresses on a 32-bit APB bus and a 50 MHz system clock.
`ifndef ICU_CFG_SVH
`define ICU_CFG_SVH
`define ICU_OFS_EXT_MODE 8'h00
`define ICU_OFS_NMI_EDGE 8'h04
`define ICU_OFS_FILT_EN 8'h08
`define ICU_OFS_SW_TRIG 8'h0c
`define ICU_OFS_PEND 8'h10
`define ICU_OFS_PEND_CLR 8'h14
`define ICU_OFS_PRIO_LO 8'h18
`define ICU_OFS_PRIO_HI 8'h1c
`define ICU_OFS_FAST_SEL 8'h20
`define ICU_OFS_TREQ_EN 8'h24
`define ICU_OFS_DMA_SEL 8'h28
`define ICU_OFS_NMI_STAT 8'h2c
`define ICU_OFS_NMI_EN 8'h30
`define ICU_OFS_NMI_CLR 8'h34
`define ICU_OFS_LP_MODE 8'h38
`define ICU_OFS_EVT_STAT 8'h3c
`define ICU_OFS_EVT_MASK 8'h40
`define ICU_FAST_EN_BIT 4
`define ICU_DMA_VALID_BIT 7
`define ICU_EXT_MODE_RST 16'h0000
`define ICU_FILT_EN_RST 9'h000
`define ICU_FILT_SAMPLES 3
`define ICU_SRC_SW 8
`define ICU_SRC_ELC 9
`define ICU_SRC_PER 12
`define ICU_NMI_PIN 0
`endif

// File: design/icu_pkg.sv
// Holds the types shared by the interrupt controller.
// Assumes nothing beyond the standard language.
`default_nettype none
package icu_pkg;
	typedef enum logic [1:0] {ICU_LP_RUN, ICU_LP_SLEEP, ICU_LP_DEEP, ICU_LP_STANDBY} icu_lp_type;
	typedef enum logic [1:0] {ICU_DET_LOW, ICU_DET_FALL, ICU_DET_RISE, ICU_DET_BOTH} icu_det_type;
	typedef logic [3:0] icu_level_type;
	typedef logic [3:0] icu_vec_type;
endpackage : icu_pkg
`default_nettype wire

// File: design/icu_top.sv
// Interrupt controller: request detection, priority arbitration, routing, wake-up.
// Assumes one 50 MHz clock, APB register access and asynchronous pins on the request lines.
//
// How it works
// R1: Eight external request pins, each with selectable low, fall, rise or both detection.
// R2: Digital noise filter on external pins and the non-maskable pin before detection.
// R3: Peripheral sources have a fixed edge or level detection per source.
// R4: One software source raised by writing its trigger register.
// R5: Three event-link sources raised by events from the event link controller.
// R6: Pending maskable requests arbitrated by software-programmed priority levels.
// R7: Exactly one source may be designated for fast interrupt handling.
// R8: Transfer-request enable bit routes a source to transfer controller, else CPU or DMA.
// R9: One activation select per DMA channel picks the starting source.
// R10: Non-maskable pin detected on falling or rising edge, software selected.
// R11: Oscillation stop raises a non-maskable interrupt.
// R12: Each watchdog error raises its own non-maskable interrupt.
// R13: Each of the two voltage monitors raises its own non-maskable interrupt.
// R14: Battery supply monitor raises a non-maskable interrupt.
// R15: Sleep and deep sleep end on non-maskable or any enabled interrupt.
// R16: Standby ends only on non-maskable, external pin, or clock alarm/period interrupts.
// R17: Each non-maskable source has status, enable and clear bits; forwarded when enabled.
// R18: Any enabled non-maskable status forces the non-maskable request regardless of priority.
`include "icu_cfg.svh"
`default_nettype none
module icu_top #(
	parameter int NPER = 4,
	parameter logic [3:0] PER_EDGE = 4'h5,
	parameter int NDMA = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] external_request_pins,
	input wire logic nmi_pin,
	input wire logic [NPER-1:0] per_req,
	input wire logic event_link_irq_a,
	input wire logic event_link_irq_b,
	input wire logic event_link_irq_c,
	input wire logic osc_stop,
	input wire logic main_watchdog_err,
	input wire logic independent_watchdog_err,
	input wire logic voltage_monitor_one,
	input wire logic voltage_monitor_two,
	input wire logic battery_supply_low,
	input wire logic rtc_alarm,
	input wire logic rtc_period,
	input wire logic cpu_ack,
	input wire logic data_transfer_controller_ack,
	input wire logic [NDMA-1:0] dma_controller_ack,
	output logic cpu_req,
	output logic fast_req,
	output icu_pkg::icu_vec_type cpu_vec,
	output icu_pkg::icu_level_type cpu_level,
	output logic data_transfer_controller_req,
	output icu_pkg::icu_vec_type dtc_vec,
	output logic [NDMA-1:0] dma_controller_req,
	output logic nmi_req,
	output logic wake,
	output logic irq
);
	import icu_pkg::*;
	localparam int NSRC = `ICU_SRC_PER + NPER;
	localparam int NSYN = 17;

	// ----------------------------------------------------------------
	// Registers and synchronisers
	// ----------------------------------------------------------------
	logic [15:0] ext_mode_q;
	logic nmi_rise_q;
	logic [8:0] filt_en_q;
	logic [NSRC-1:0] pend_q;
	icu_level_type prio_q [NSRC];
	logic [4:0] fast_sel_q;
	logic [NSRC-1:0] treq_q;
	logic [7:0] dma_sel_q [NDMA];
	logic [6:0] nmi_stat_q, nmi_en_q;
	icu_lp_type lp_q;
	logic [1:0] evt_stat_q, evt_mask_q;
	logic [NSYN-1:0] sync1_q, sync2_q, prev_q;
	logic [8:0] filt_q, filt_prev_q;
	logic [NPER-1:0] per_prev_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, cpu_req_q, fast_req_q, dtc_req_q, nmi_req_q, wake_q, irq_q;
	icu_vec_type cpu_vec_q, dtc_vec_q;
	icu_level_type cpu_level_q;
	logic [NDMA-1:0] dma_req_q;

	logic setup, wr_en;
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready_q & pwrite;

	function automatic logic dma_hit(input logic [7:0] sel, input int src);
		dma_hit = sel[`ICU_DMA_VALID_BIT] & (int'(sel[3:0]) == src);
	endfunction : dma_hit

	// Pins and foreign-domain levels pass two flip-flops before use.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_q <= '1;
			sync2_q <= '1;
		end else begin
			sync1_q <= {rtc_period, rtc_alarm, battery_supply_low, voltage_monitor_two,
				voltage_monitor_one, independent_watchdog_err, main_watchdog_err,
				osc_stop, nmi_pin, external_request_pins};
			sync2_q <= sync1_q;
		end
	end

	// ----------------------------------------------------------------
	// Noise filter
	// ----------------------------------------------------------------
	// A level must hold for several samples; this trades latency for glitch immunity.
	genvar gi;
	generate
		for (gi = 0; gi < 9; gi++) begin : g_filt
			logic [1:0] cnt_q;
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					cnt_q <= 2'h0;
					filt_q[gi] <= 1'b1;
				end else if (!filt_en_q[gi] || sync2_q[gi] == filt_q[gi]) begin // [R2]
					cnt_q <= 2'h0;
					filt_q[gi] <= sync2_q[gi];
				end else if (cnt_q == 2'(`ICU_FILT_SAMPLES - 1)) begin
					cnt_q <= 2'h0;
					filt_q[gi] <= sync2_q[gi];
				end else begin
					cnt_q <= cnt_q + 2'h1;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			filt_prev_q <= '1;
			prev_q <= '1;
			per_prev_q <= '0;
		end else begin
			filt_prev_q <= filt_q;
			prev_q <= sync2_q;
			per_prev_q <= per_req;
		end
	end

	// ----------------------------------------------------------------
	// Detection
	// ----------------------------------------------------------------
	logic [NSRC-1:0] set_v, level_v, clr_v, pend_eff;
	always_comb begin
		set_v = '0;
		level_v = '0;
		for (int i = 0; i < 8; i++) begin
			case (icu_det_type'(ext_mode_q[2*i +: 2])) // [R1]
				ICU_DET_LOW: level_v[i] = ~filt_q[i];
				ICU_DET_FALL: set_v[i] = filt_prev_q[i] & ~filt_q[i];
				ICU_DET_RISE: set_v[i] = ~filt_prev_q[i] & filt_q[i];
				ICU_DET_BOTH: set_v[i] = filt_prev_q[i] ^ filt_q[i];
				default: set_v[i] = 1'b0;
			endcase
		end
		set_v[`ICU_SRC_SW] = wr_en && paddr == `ICU_OFS_SW_TRIG; // [R4]
		set_v[`ICU_SRC_ELC +: 3] = {event_link_irq_c, event_link_irq_b, event_link_irq_a}; // [R5]
		for (int i = 0; i < NPER; i++) begin
			if (PER_EDGE[i]) begin // [R3]
				set_v[`ICU_SRC_PER + i] = per_req[i] & ~per_prev_q[i];
			end else begin
				level_v[`ICU_SRC_PER + i] = per_req[i];
			end
		end
		clr_v = (wr_en && paddr == `ICU_OFS_PEND_CLR) ? pwdata[NSRC-1:0] : '0;
		if (cpu_ack) begin
			clr_v[cpu_vec_q] = 1'b1;
		end
		if (data_transfer_controller_ack) begin
			clr_v[dtc_vec_q] = 1'b1;
		end
		for (int m = 0; m < NDMA; m++) begin
			if (dma_controller_ack[m] && dma_sel_q[m][`ICU_DMA_VALID_BIT]) begin
				clr_v[dma_sel_q[m][3:0]] = 1'b1;
			end
		end
		pend_eff = pend_q | level_v;
	end

	// An event in the same cycle as its clear keeps the flag set.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pend_q <= '0;
		end else begin
			pend_q <= set_v | (pend_q & ~clr_v);
		end
	end

	// ----------------------------------------------------------------
	// Arbitration and routing
	// ----------------------------------------------------------------
	logic best_ok, dtc_ok;
	icu_vec_type best_idx, dtc_idx;
	icu_level_type best_lvl;
	logic [NSRC-1:0] to_dma;
	always_comb begin
		best_ok = 1'b0;
		best_idx = '0;
		best_lvl = '0;
		dtc_ok = 1'b0;
		dtc_idx = '0;
		to_dma = '0;
		for (int j = NSRC - 1; j >= 0; j--) begin
			for (int m = 0; m < NDMA; m++) begin
				to_dma[j] = to_dma[j] | dma_hit(dma_sel_q[m], j); // [R9]
			end
			if (pend_eff[j] && prio_q[j] != 4'h0) begin
				if (treq_q[j]) begin // [R8]
					dtc_ok = 1'b1;
					dtc_idx = 4'(j);
				end else if (!to_dma[j] && prio_q[j] >= best_lvl) begin // [R6]
					best_ok = 1'b1;
					best_idx = 4'(j);
					best_lvl = prio_q[j];
				end
			end
		end
	end

	logic is_fast;
	assign is_fast = fast_sel_q[`ICU_FAST_EN_BIT] && fast_sel_q[3:0] == best_idx;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_req_q <= 1'b0;
			fast_req_q <= 1'b0;
			cpu_vec_q <= '0;
			cpu_level_q <= '0;
			dtc_req_q <= 1'b0;
			dtc_vec_q <= '0;
			dma_req_q <= '0;
		end else begin
			cpu_req_q <= best_ok & ~is_fast & ~cpu_ack;
			fast_req_q <= best_ok & is_fast & ~cpu_ack; // [R7]
			cpu_vec_q <= best_idx;
			cpu_level_q <= best_lvl;
			dtc_req_q <= dtc_ok & ~data_transfer_controller_ack; // [R8]
			dtc_vec_q <= dtc_idx;
			for (int m = 0; m < NDMA; m++) begin
				dma_req_q[m] <= dma_sel_q[m][`ICU_DMA_VALID_BIT] & ~dma_controller_ack[m]
					& pend_eff[dma_sel_q[m][3:0]] & ~treq_q[dma_sel_q[m][3:0]]; // [R9]
			end
		end
	end

	// ----------------------------------------------------------------
	// Non-maskable sources
	// ----------------------------------------------------------------
	logic [6:0] nmi_ev, nmi_clr;
	always_comb begin
		nmi_ev[`ICU_NMI_PIN] = nmi_rise_q ? (~filt_prev_q[8] & filt_q[8])
			: (filt_prev_q[8] & ~filt_q[8]); // [R10]
		nmi_ev[1] = sync2_q[9] & ~prev_q[9]; // [R11]
		nmi_ev[3:2] = sync2_q[11:10] & ~prev_q[11:10]; // [R12]
		nmi_ev[5:4] = sync2_q[13:12] & ~prev_q[13:12]; // [R13]
		nmi_ev[6] = sync2_q[14] & ~prev_q[14]; // [R14]
		nmi_clr = (wr_en && paddr == `ICU_OFS_NMI_CLR) ? pwdata[6:0] : 7'h00;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nmi_stat_q <= '0;
			nmi_req_q <= 1'b0;
		end else begin
			nmi_stat_q <= nmi_ev | (nmi_stat_q & ~nmi_clr); // [R17]
			nmi_req_q <= |(nmi_stat_q & nmi_en_q); // [R18]
		end
	end

	// ----------------------------------------------------------------
	// Low-power wake-up
	// ----------------------------------------------------------------
	logic wake_cond;
	always_comb begin
		case (lp_q)
			ICU_LP_SLEEP, ICU_LP_DEEP: begin
				wake_cond = nmi_req_q || best_ok || dtc_ok || (|dma_req_q); // [R15]
			end
			ICU_LP_STANDBY: begin
				wake_cond = nmi_req_q || (|pend_eff[7:0]) || (|(sync2_q[16:15] & ~prev_q[16:15])); // [R16]
			end
			default: wake_cond = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_mode_q <= `ICU_EXT_MODE_RST;
			nmi_rise_q <= 1'b0;
			filt_en_q <= `ICU_FILT_EN_RST;
			fast_sel_q <= '0;
			treq_q <= '0;
			nmi_en_q <= '0;
			evt_mask_q <= '0;
			for (int j = 0; j < NSRC; j++) begin
				prio_q[j] <= '0;
			end
			for (int m = 0; m < NDMA; m++) begin
				dma_sel_q[m] <= '0;
			end
		end else if (wr_en) begin
			case (paddr)
				`ICU_OFS_EXT_MODE: ext_mode_q <= pwdata[15:0];
				`ICU_OFS_NMI_EDGE: nmi_rise_q <= pwdata[0];
				`ICU_OFS_FILT_EN: filt_en_q <= pwdata[8:0];
				`ICU_OFS_PRIO_LO, `ICU_OFS_PRIO_HI: begin
					for (int j = 0; j < 8; j++) begin
						if (int'(paddr[2]) * 8 + j < NSRC) begin
							prio_q[int'(paddr[2]) * 8 + j] <= pwdata[4*j +: 4];
						end
					end
				end
				`ICU_OFS_FAST_SEL: fast_sel_q <= pwdata[4:0]; // [R7]
				`ICU_OFS_TREQ_EN: treq_q <= pwdata[NSRC-1:0];
				`ICU_OFS_DMA_SEL: begin
					for (int m = 0; m < NDMA; m++) begin
						dma_sel_q[m] <= pwdata[8*m +: 8];
					end
				end
				`ICU_OFS_NMI_EN: nmi_en_q <= pwdata[6:0];
				`ICU_OFS_EVT_MASK: evt_mask_q <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// Low-power mode is entered by software and left by the wake condition or by a software write of the mode register.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lp_q <= ICU_LP_RUN;
			wake_q <= 1'b0;
		end else begin
			wake_q <= wake_cond;
			if (wake_cond) begin
				lp_q <= ICU_LP_RUN;
			end else if (wr_en && paddr == `ICU_OFS_LP_MODE) begin
				lp_q <= icu_lp_type'(pwdata[1:0]);
			end
		end
	end

	// Event status: bit 0 wake-up, bit 1 any non-maskable event; write one to clear.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			evt_stat_q <= '0;
			irq_q <= 1'b0;
		end else begin
			evt_stat_q <= {|nmi_ev, wake_cond} | (evt_stat_q
				& ~((wr_en && paddr == `ICU_OFS_EVT_STAT) ? pwdata[1:0] : 2'h0));
			irq_q <= |(evt_stat_q & evt_mask_q);
		end
	end

	// Reads are prepared in the setup cycle, so every access has exactly one access cycle.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata_q <= '0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
			if (setup) begin
				case (paddr)
					`ICU_OFS_EXT_MODE: prdata_q <= {16'h0000, ext_mode_q};
					`ICU_OFS_NMI_EDGE: prdata_q <= {31'h0, nmi_rise_q};
					`ICU_OFS_FILT_EN: prdata_q <= {23'h0, filt_en_q};
					`ICU_OFS_PEND: prdata_q <= 32'(pend_eff);
					`ICU_OFS_PRIO_LO, `ICU_OFS_PRIO_HI: begin
						for (int j = 0; j < 8; j++) begin
							if (int'(paddr[2]) * 8 + j < NSRC) begin
								prdata_q[4*j +: 4] <= prio_q[int'(paddr[2]) * 8 + j];
							end
						end
					end
					`ICU_OFS_FAST_SEL: prdata_q <= {27'h0, fast_sel_q};
					`ICU_OFS_TREQ_EN: prdata_q <= 32'(treq_q);
					`ICU_OFS_DMA_SEL: begin
						for (int m = 0; m < NDMA; m++) begin
							prdata_q[8*m +: 8] <= dma_sel_q[m];
						end
					end
					`ICU_OFS_NMI_STAT: prdata_q <= {25'h0, nmi_stat_q};
					`ICU_OFS_NMI_EN: prdata_q <= {25'h0, nmi_en_q};
					`ICU_OFS_LP_MODE: prdata_q <= {30'h0, lp_q};
					`ICU_OFS_EVT_STAT: prdata_q <= {30'h0, evt_stat_q};
					`ICU_OFS_EVT_MASK: prdata_q <= {30'h0, evt_mask_q};
					`ICU_OFS_SW_TRIG, `ICU_OFS_PEND_CLR, `ICU_OFS_NMI_CLR: prdata_q <= '0;
					default: pslverr_q <= 1'b1;
				endcase
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign cpu_req = cpu_req_q;
	assign fast_req = fast_req_q;
	assign cpu_vec = cpu_vec_q;
	assign cpu_level = cpu_level_q;
	assign data_transfer_controller_req = dtc_req_q;
	assign dtc_vec = dtc_vec_q;
	assign dma_controller_req = dma_req_q;
	assign nmi_req = nmi_req_q;
	assign wake = wake_q;
	assign irq = irq_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	apb_ready_a: assert property (setup |=> pready_q ##1 !pready_q) // [R4]
		else $error("APB answer not one cycle after setup");
	sw_trigger_a: assert property (wr_en && paddr == `ICU_OFS_SW_TRIG |=> pend_q[`ICU_SRC_SW]) // [R4]
		else $error("Software trigger did not set pending");
	fast_excl_a: assert property (!(fast_req_q && cpu_req_q)) // [R7]
		else $error("Fast and normal request together");
	dtc_route_a: assert property (dtc_req_q |-> $past(treq_q[dtc_idx])) // [R8]
		else $error("Transfer request for unrouted source");
	nmi_forward_a: assert property ((|(nmi_stat_q & nmi_en_q)) |=> nmi_req_q) // [R18]
		else $error("Enabled non-maskable status not forwarded");
	nmi_gate_a: assert property (nmi_req_q |-> $past(|(nmi_stat_q & nmi_en_q))) // [R17]
		else $error("Non-maskable request without enabled status");
	osc_stop_a: assert property (nmi_ev[1] |=> nmi_stat_q[1]) // [R11]
		else $error("Oscillation stop not latched");
	standby_wake_a: assert property (lp_q == ICU_LP_STANDBY && !nmi_req_q && pend_eff[7:0] == 8'h00
		&& !(|(sync2_q[16:15] & ~prev_q[16:15])) |=> !wake_q) // [R16]
		else $error("Standby left without allowed source");
	sleep_wake_a: assert property ((lp_q == ICU_LP_SLEEP || lp_q == ICU_LP_DEEP) // [R15]
		&& nmi_req_q |=> wake_q && lp_q == ICU_LP_RUN)
		else $error("Sleep not ended by non-maskable request");
	irq_level_a: assert property (|(evt_stat_q & evt_mask_q) |=> irq_q) // [R15]
		else $error("Interrupt output not raised");
	cpu_req_c: cover property (best_ok ##1 cpu_req_q ##[1:20] cpu_ack);
	fast_req_c: cover property (fast_req_q);
	standby_wake_c: cover property (lp_q == ICU_LP_STANDBY ##1 wake_q);
endmodule : icu_top
`default_nettype wire

// File: testbench/icu_far.sv
// Far-side model: CPU core, transfer controller and DMA channels answering requests.
// Assumes registered request levels on one clock; stall holds every answer back.
`default_nettype none
module icu_far #(
	parameter int NDMA = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic stall,
	input wire logic cpu_req,
	input wire logic fast_req,
	input wire logic dtc_req,
	input wire logic [NDMA-1:0] dma_req,
	input wire icu_pkg::icu_vec_type cpu_vec,
	input wire icu_pkg::icu_level_type cpu_level,
	output logic cpu_ack,
	output logic dtc_ack,
	output logic [NDMA-1:0] dma_ack,
	output icu_pkg::icu_vec_type last_vec,
	output icu_pkg::icu_level_type last_lvl,
	output int cpu_cnt,
	output int fast_cnt,
	output int dtc_cnt,
	output int dma_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	import icu_pkg::*;
	// ----
	// Answers
	// ----
	// An answer lasts one cycle and is never given twice in a row, because a request
	// only drops in the cycle after its acknowledge.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{cpu_ack, dtc_ack, dma_ack, last_vec, last_lvl} <= '0;
			{cpu_cnt, fast_cnt, dtc_cnt, dma_cnt} <= '0;
		end else if (cpu_ack || dtc_ack || (|dma_ack) || stall) begin
			{cpu_ack, dtc_ack, dma_ack} <= '0;
		end else begin
			cpu_ack <= cpu_req | fast_req;
			dtc_ack <= dtc_req;
			dma_ack <= dma_req;
			cpu_cnt <= cpu_cnt + int'(cpu_req | fast_req);
			fast_cnt <= fast_cnt + int'(fast_req);
			dtc_cnt <= dtc_cnt + int'(dtc_req);
			dma_cnt <= dma_cnt + int'(|dma_req);
			if (cpu_req | fast_req) begin
				last_vec <= cpu_vec;
				last_lvl <= cpu_level;
			end
		end
	end
endmodule : icu_far
`default_nettype wire

// File: testbench/icu_top_test.sv
// Self-checking bench of the interrupt controller top beside its far-side model.
// Assumes the design files and icu_cfg.svh are compiled first.
`include "icu_cfg.svh"
`default_nettype none
`define CHK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
	end \
end
module icu_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import icu_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, err;
	logic [7:0] pins = 8'hff;
	logic npin = 1'b1, stall = 1'b0;
	logic [3:0] per = '0;
	logic [2:0] evt = '0;
	logic [6:1] nsrc = '0;
	logic [1:0] rtc = '0;
	logic cpu_ack, dtc_ack, cpu_req, fast_req, dtc_req, nmi_req, wake, irq;
	logic [3:0] dma_ack, dma_req;
	icu_vec_type cpu_vec, last_vec, dtc_vec, dtc_seen;
	icu_level_type cpu_level, last_lvl;
	int cpu_cnt, fast_cnt, dtc_cnt, dma_cnt;
	int wake_cnt = 0, error_cnt = 0, checks_done = 0;
	// ----
	// Design and far side
	// ----
	icu_top #(.NPER(4), .PER_EDGE(4'h5), .NDMA(4)) i_icu_top (
		.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_request_pins(pins), .nmi_pin(npin), .per_req(per),
		.event_link_irq_a(evt[0]), .event_link_irq_b(evt[1]), .event_link_irq_c(evt[2]),
		.osc_stop(nsrc[1]), .main_watchdog_err(nsrc[2]), .independent_watchdog_err(nsrc[3]),
		.voltage_monitor_one(nsrc[4]), .voltage_monitor_two(nsrc[5]),
		.battery_supply_low(nsrc[6]), .rtc_alarm(rtc[0]), .rtc_period(rtc[1]),
		.cpu_ack(cpu_ack), .data_transfer_controller_ack(dtc_ack), .dma_controller_ack(dma_ack),
		.cpu_req(cpu_req), .fast_req(fast_req), .cpu_vec(cpu_vec), .cpu_level(cpu_level),
		.data_transfer_controller_req(dtc_req), .dtc_vec(dtc_vec), .dma_controller_req(dma_req),
		.nmi_req(nmi_req), .wake(wake), .irq(irq));
	icu_far #(.NDMA(4)) i_icu_far (
		.clk(clk), .reset_n(reset_n), .stall(stall), .cpu_req(cpu_req), .fast_req(fast_req),
		.dtc_req(dtc_req), .dma_req(dma_req), .cpu_vec(cpu_vec), .cpu_level(cpu_level),
		.cpu_ack(cpu_ack), .dtc_ack(dtc_ack), .dma_ack(dma_ack), .last_vec(last_vec),
		.last_lvl(last_lvl), .cpu_cnt(cpu_cnt), .fast_cnt(fast_cnt), .dtc_cnt(dtc_cnt),
		.dma_cnt(dma_cnt));
	initial begin
		forever #10 clk = ~clk;
	end
	// Wake is a one-cycle pulse, so it is counted at every edge.
	always @(posedge clk) begin
		if (wake === 1'b1) begin
			wake_cnt++;
		end
		if (dtc_req === 1'b1) begin
			dtc_seen = dtc_vec;
		end
	end
	// ----
	// Bus and helpers
	// ----
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask : rd_chk
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	// ----
	// Scenarios
	// ----
	task automatic t_regs();
		rd_chk(`ICU_OFS_NMI_STAT, 32'h0);
		apb(1'b1, `ICU_OFS_TREQ_EN, 32'h5a);
		rd_chk(`ICU_OFS_TREQ_EN, 32'h5a);
		apb(1'b1, `ICU_OFS_NMI_STAT, 32'hff);
		rd_chk(`ICU_OFS_NMI_STAT, 32'h0);
		rd_chk(8'h80, 32'h0);
		`CHK(err, 1'b1)
		apb(1'b1, `ICU_OFS_TREQ_EN, 32'h0);
	endtask : t_regs
	// Requests are held back by the far side so that the pending word can be read.
	task automatic t_pins();
		logic [1:0] m;
		stall <= 1'b1;
		apb(1'b1, `ICU_OFS_PRIO_LO, 32'h1100);
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			apb(1'b1, `ICU_OFS_EXT_MODE, 32'(m) << 4);
			pins[2] <= 1'b0;
			tick(8);
			rd_chk(`ICU_OFS_PEND, 32'(m != ICU_DET_RISE) << 2);
			pins[2] <= 1'b1;
			tick(8);
			if (m != ICU_DET_LOW) begin
				rd_chk(`ICU_OFS_PEND, 32'h4);
			end
			apb(1'b1, `ICU_OFS_PEND_CLR, 32'h4);
			rd_chk(`ICU_OFS_PEND, 32'h0);
		end
		apb(1'b1, `ICU_OFS_FILT_EN, 32'h8);
		apb(1'b1, `ICU_OFS_EXT_MODE, 32'h40);
		pins[3] <= 1'b0;
		tick(2);
		pins[3] <= 1'b1;
		tick(10);
		rd_chk(`ICU_OFS_PEND, 32'h0);
		pins[3] <= 1'b0;
		tick(6);
		pins[3] <= 1'b1;
		tick(10);
		rd_chk(`ICU_OFS_PEND, 32'h8);
		apb(1'b1, `ICU_OFS_PEND_CLR, 32'h8);
		tick(3);
		stall <= 1'b0;
	endtask : t_pins
	task automatic pin4_fall();
		pins[4] <= 1'b0;
		tick(20);
		pins[4] <= 1'b1;
		tick(4);
	endtask : pin4_fall
	task automatic t_route();
		int c0;
		c0 = cpu_cnt;
		apb(1'b1, `ICU_OFS_EXT_MODE, 32'h100);
		apb(1'b1, `ICU_OFS_PRIO_LO, 32'h10000);
		apb(1'b1, `ICU_OFS_TREQ_EN, 32'h10);
		pin4_fall();
		`CHK(dtc_cnt, 1)
		`CHK(dtc_seen, 4'h4)
		apb(1'b1, `ICU_OFS_TREQ_EN, 32'h0);
		apb(1'b1, `ICU_OFS_DMA_SEL, 32'h84);
		pin4_fall();
		`CHK(dma_cnt, 1)
		`CHK(cpu_cnt, c0)
		apb(1'b1, `ICU_OFS_DMA_SEL, 32'h0);
		pin4_fall();
		`CHK(cpu_cnt, c0 + 1)
		`CHK(last_vec, 4'h4)
	endtask : t_route
	task automatic t_prio();
		int c0;
		c0 = cpu_cnt;
		apb(1'b1, `ICU_OFS_PRIO_HI, 32'h0011_0523);
		apb(1'b1, `ICU_OFS_SW_TRIG, 32'h1);
		tick(20);
		`CHK(cpu_cnt, c0 + 1)
		`CHK(last_vec, 4'h8)
		`CHK(last_lvl, 4'h3)
		apb(1'b1, `ICU_OFS_FAST_SEL, 32'h18);
		apb(1'b1, `ICU_OFS_SW_TRIG, 32'h1);
		tick(20);
		`CHK(fast_cnt, 1)
		apb(1'b1, `ICU_OFS_FAST_SEL, 32'h0);
		stall <= 1'b1;
		evt <= 3'b111;
		@(posedge clk);
		evt <= 3'b000;
		tick(10);
		stall <= 1'b0;
		tick(2);
		`CHK(last_vec, 4'ha)
		`CHK(last_lvl, 4'h5)
		tick(20);
		`CHK(last_vec, 4'h9)
		`CHK(cpu_cnt, c0 + 4)
		c0 = cpu_cnt;
		per <= 4'h1;
		tick(30);
		`CHK(cpu_cnt, c0 + 1)
		per <= 4'h2;
		tick(30);
		`CHK(cpu_cnt > c0 + 2, 1'b1)
		per <= 4'h0;
		tick(20);
	endtask : t_prio
	task automatic t_nmi();
		apb(1'b1, `ICU_OFS_NMI_EN, 32'h7f);
		for (int e = 0; e < 2; e++) begin
			apb(1'b1, `ICU_OFS_NMI_EDGE, 32'(e));
			npin <= 1'b0;
			tick(8);
			rd_chk(`ICU_OFS_NMI_STAT, 32'(e == 0));
			apb(1'b1, `ICU_OFS_NMI_CLR, 32'h1);
			npin <= 1'b1;
			tick(8);
			rd_chk(`ICU_OFS_NMI_STAT, 32'(e == 1));
			apb(1'b1, `ICU_OFS_NMI_CLR, 32'h1);
		end
		for (int i = 1; i < 7; i++) begin
			nsrc[i] <= 1'b1;
			tick(8);
			rd_chk(`ICU_OFS_NMI_STAT, 32'h1 << i);
			`CHK(nmi_req, 1'b1)
			nsrc[i] <= 1'b0;
			apb(1'b1, `ICU_OFS_NMI_CLR, 32'h1 << i);
			tick(2);
			`CHK(nmi_req, 1'b0)
		end
		apb(1'b1, `ICU_OFS_NMI_EN, 32'h7d);
		nsrc[1] <= 1'b1;
		tick(8);
		rd_chk(`ICU_OFS_NMI_STAT, 32'h2);
		`CHK(nmi_req, 1'b0)
		nsrc[1] <= 1'b0;
		apb(1'b1, `ICU_OFS_NMI_CLR, 32'h2);
	endtask : t_nmi
	task automatic t_wake();
		int c0;
		apb(1'b1, `ICU_OFS_EVT_MASK, 32'h0);
		apb(1'b1, `ICU_OFS_EVT_STAT, 32'h3);
		c0 = wake_cnt;
		apb(1'b1, `ICU_OFS_LP_MODE, 32'h1);
		apb(1'b1, `ICU_OFS_SW_TRIG, 32'h1);
		tick(20);
		`CHK(wake_cnt, c0 + 1)
		apb(1'b1, `ICU_OFS_LP_MODE, 32'h2);
		nsrc[2] <= 1'b1;
		tick(10);
		nsrc[2] <= 1'b0;
		`CHK(wake_cnt, c0 + 2)
		apb(1'b1, `ICU_OFS_NMI_CLR, 32'h4);
		apb(1'b1, `ICU_OFS_LP_MODE, 32'h3);
		apb(1'b1, `ICU_OFS_SW_TRIG, 32'h1);
		tick(20);
		`CHK(wake_cnt, c0 + 2)
		rtc[0] <= 1'b1;
		tick(20);
		rtc[0] <= 1'b0;
		`CHK(wake_cnt, c0 + 3)
		rd_chk(`ICU_OFS_EVT_STAT, 32'h3);
		`CHK(irq, 1'b0)
		apb(1'b1, `ICU_OFS_EVT_MASK, 32'h1);
		tick(1);
		`CHK(irq, 1'b1)
		apb(1'b1, `ICU_OFS_EVT_STAT, 32'h3);
		tick(1);
		`CHK(irq, 1'b0)
		rd_chk(`ICU_OFS_EVT_STAT, 32'h0);
	endtask : t_wake
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_pins();
		t_route();
		t_prio();
		t_nmi();
		t_wake();
		report_and_stop();
	end
	// The whole sequence needs under a thousand cycles; the limit leaves wide room.
	initial begin
		tick(20000);
		error_cnt++;
		report_and_stop();
	end
endmodule : icu_top_test
`default_nettype wire
